// *** src/bmxc_pkg.sv ***
// ***************************************************************
// Shared constants and types of the bus matrix configuration block.
// ***************************************************************
package bmxc_pkg;

  // Number of bus initiators watched by the matrix.
  localparam int unsigned NUM_INIT = 5;

  // Initiator indices, in the order of their error enable bits.
  localparam int unsigned INIT_FETCH = 0;
  localparam int unsigned INIT_DATA = 1;
  localparam int unsigned INIT_DMA = 2;
  localparam int unsigned INIT_DEBUG = 3;
  localparam int unsigned INIT_SHARED = 4;

  // Register byte addresses.
  localparam logic [3:0] ADDR_MATRIX_CONFIGURATION = 4'h0;
  localparam logic [3:0] ADDR_ERROR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ERROR_CLEAR = 4'h8;
  localparam logic [3:0] ADDR_ERROR_ENABLE = 4'hC;

  // Field positions of the matrix configuration register.
  localparam int unsigned POS_ERR_ENABLE_LO = 16;
  localparam int unsigned POS_DATA_RAM_WAIT = 6;
  localparam int unsigned POS_ARB_LO = 0;
  localparam int unsigned WIDTH_ARB = 3;

  // Implemented bits and reset value of the matrix configuration register.
  localparam logic [31:0] CFG_WRITE_MASK = 32'h001F0047;
  localparam logic [31:0] CFG_RESET = 32'h001F0041;

  // Implemented bits of the error status, clear and enable registers.
  localparam logic [31:0] EVT_MASK = 32'h0000001F;
  localparam logic [4:0] EVT_RESET = 5'h00;

  // Arbitration mode codes.
  localparam logic [2:0] ARB_MODE0 = 3'h0;
  localparam logic [2:0] ARB_MODE1 = 3'h1;
  localparam logic [2:0] ARB_MODE2 = 3'h2;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Requests offered by the initiators, one bit per initiator.
  typedef struct packed {
    logic [NUM_INIT-1:0] valid;
    logic [NUM_INIT-1:0] unmapped;
    logic [NUM_INIT-1:0] data_ram;
  } bmxc_req_t;

  // Answers given to the initiators, one bit per initiator.
  typedef struct packed {
    logic [NUM_INIT-1:0] target_strobe;
    logic [NUM_INIT-1:0] ack;
    logic [NUM_INIT-1:0] err;
  } bmxc_rsp_t;

endpackage

// *** src/bmxc_top.sv ***
// Operation
// - A one in bit 20 lets unmapped accesses from the shared peripheral bus raise a bus error, a zero suppresses it.
// - A one in bit 19 lets unmapped accesses from the debug unit raise a bus error, a zero suppresses it.
// - A one in bit 17 lets unmapped CPU data accesses raise a bus error, except while the CPU is in debug mode.
// - A one in bit 16 lets unmapped CPU fetches raise a bus error, except while the CPU is in debug mode.
// - A one in bit 6 adds one address setup wait state to every CPU access of data RAM.
// - Bits 2 to 0 pick the arbitration scheme, with codes 000, 001 (reset) and 010 for modes 0, 1 and 2.
// - Bits 31 to 21, 15 to 7 and 5 to 3 read as zero and ignore writes.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module bmxc_top (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Initiator side.
  input wire bmxc_pkg::bmxc_req_t init_req,
  input wire logic cpu_debug_mode,
  output bmxc_pkg::bmxc_rsp_t init_rsp,
  // Interrupt.
  output logic irq
);

  // ***************************************************************
  // Declarations
  // ***************************************************************

  typedef enum logic [1:0] {
    BMXC_IDLE,
    BMXC_SETUP,
    BMXC_XFER,
    BMXC_DONE
  } bmxc_state_t;

  localparam int unsigned N = bmxc_pkg::NUM_INIT;

  bmxc_state_t state_q;
  logic [31:0] cfg_q;
  logic [N-1:0] status_q;
  logic [N-1:0] enable_q;
  logic [N-1:0] cur_q;
  logic [N-1:0] last_q;
  bmxc_pkg::bmxc_rsp_t rsp_q;
  logic irq_q;

  logic awready_q;
  logic [3:0] aw_addr_q;
  logic wready_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic arready_q;

  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;
  logic [N-1:0] clear_hit;
  logic [N-1:0] err_enable;
  logic [N-1:0] winner;
  logic [N-1:0] evt_set;
  logic [2:0] arb_mode;
  logic cpu_pick;

  // ***************************************************************
  // Helper functions
  // ***************************************************************

  // Lowest requesting index wins.
  function automatic logic [N-1:0] pick_low(input logic [N-1:0] req);
    logic [N-1:0] g;
    g = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  // Highest requesting index wins.
  function automatic logic [N-1:0] pick_high(input logic [N-1:0] req);
    logic [N-1:0] g;
    g = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  // First requester above the last winner wins, wrapping round.
  function automatic logic [N-1:0] pick_rotate(input logic [N-1:0] req, input logic [N-1:0] last);
    logic [N-1:0] above;
    logic seen;
    above = '0;
    seen = 1'b0;
    for (int i = 0; i < N; i++) begin
      above[i] = seen & req[i];
      seen = seen | last[i];
    end
    return (|above) ? pick_low(above) : pick_low(req);
  endfunction

  // ***************************************************************
  // Access checking and arbitration
  // ***************************************************************

  // Effective error enables; the CPU checks are gated off in debug mode.
  always_comb begin
    err_enable = cfg_q[bmxc_pkg::POS_ERR_ENABLE_LO +: N];
    err_enable[bmxc_pkg::INIT_FETCH] = err_enable[bmxc_pkg::INIT_FETCH] & ~cpu_debug_mode;
    err_enable[bmxc_pkg::INIT_DATA] = err_enable[bmxc_pkg::INIT_DATA] & ~cpu_debug_mode;
  end

  // Winner among the requests; reserved codes fall back to mode 1 since software must not use them.
  assign arb_mode = cfg_q[bmxc_pkg::POS_ARB_LO +: bmxc_pkg::WIDTH_ARB];
  always_comb begin
    case (arb_mode)
      bmxc_pkg::ARB_MODE0: winner = pick_low(init_req.valid);
      bmxc_pkg::ARB_MODE1: winner = pick_high(init_req.valid);
      bmxc_pkg::ARB_MODE2: winner = pick_rotate(init_req.valid, last_q);
      default: winner = pick_high(init_req.valid);
    endcase
  end

  // A CPU access of data RAM is the only kind that can take the setup wait state.
  assign cpu_pick = |(winner & init_req.data_ram & ~init_req.unmapped &
                      ((N)'(1) << bmxc_pkg::INIT_FETCH | (N)'(1) << bmxc_pkg::INIT_DATA));

  // Error events raised on an enabled unmapped access.
  assign evt_set = (state_q == BMXC_IDLE) ? (winner & init_req.unmapped & err_enable) : '0;

  // Access sequencer: one access at a time, answered in the cycle spent in DONE.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= BMXC_IDLE;
      cur_q <= '0;
      last_q <= '0;
      rsp_q <= '0;
    end else begin
      case (state_q)
        BMXC_IDLE: begin
          rsp_q <= '0;
          if (|winner) begin
            cur_q <= winner;
            last_q <= winner;
            if (|(winner & init_req.unmapped)) begin
              // Unmapped accesses never reach a target, whatever the enables hold.
              rsp_q.err <= winner & err_enable;
              rsp_q.ack <= winner & ~err_enable;
              state_q <= BMXC_DONE;
            end else if (cpu_pick && cfg_q[bmxc_pkg::POS_DATA_RAM_WAIT]) begin
              state_q <= BMXC_SETUP;
            end else begin
              rsp_q.target_strobe <= winner;
              state_q <= BMXC_XFER;
            end
          end
        end
        BMXC_SETUP: begin
          // Address setup cycle; the target strobe follows one cycle late.
          rsp_q.target_strobe <= cur_q;
          state_q <= BMXC_XFER;
        end
        BMXC_XFER: begin
          rsp_q.target_strobe <= '0;
          rsp_q.ack <= cur_q;
          state_q <= BMXC_DONE;
        end
        BMXC_DONE: begin
          // The answer stands here; the initiator drops its request at the same edge.
          rsp_q <= '0;
          state_q <= BMXC_IDLE;
        end
        default: begin
          rsp_q <= '0;
          state_q <= BMXC_IDLE;
        end
      endcase
    end
  end

  assign init_rsp = rsp_q;

  // ***************************************************************
  // AXI4-Lite write path
  // ***************************************************************

  // Address and data may arrive in either order; each is held until both are in.
  // The ready flags are kept as flops themselves, so the outputs need no inverter behind the register.
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_addr_q <= 4'h0;
      wready_q <= 1'b1;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        wready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;

  // Byte enables widened to a bit mask.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{w_strb_q[b]}};
    end
  end

  // Write response; unknown offsets are answered with SLVERR and change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= bmxc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      case (aw_addr_q)
        bmxc_pkg::ADDR_MATRIX_CONFIGURATION,
        bmxc_pkg::ADDR_ERROR_CLEAR,
        bmxc_pkg::ADDR_ERROR_ENABLE: bresp_q <= bmxc_pkg::RESP_OKAY;
        default: bresp_q <= bmxc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ***************************************************************
  // Registers
  // ***************************************************************

  // Matrix configuration; only implemented bits take the write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= bmxc_pkg::CFG_RESET;
    end else if (wr_fire && aw_addr_q == bmxc_pkg::ADDR_MATRIX_CONFIGURATION) begin
      cfg_q <= (cfg_q & ~(wmask & bmxc_pkg::CFG_WRITE_MASK)) |
               (w_data_q & wmask & bmxc_pkg::CFG_WRITE_MASK);
    end
  end

  // Interrupt enable register, same layout as the status register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= bmxc_pkg::EVT_RESET;
    end else if (wr_fire && aw_addr_q == bmxc_pkg::ADDR_ERROR_ENABLE && w_strb_q[0]) begin
      enable_q <= w_data_q[N-1:0];
    end
  end

  // Sticky error status; a new event wins over a clear written in the same cycle.
  assign clear_hit = (wr_fire && aw_addr_q == bmxc_pkg::ADDR_ERROR_CLEAR && w_strb_q[0]) ?
                     w_data_q[N-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= bmxc_pkg::EVT_RESET;
    end else begin
      status_q <= (status_q & ~clear_hit) | evt_set;
    end
  end

  // Level interrupt, registered so the output comes from a flip-flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((status_q & ~clear_hit) | evt_set) & enable_q);
    end
  end

  assign irq = irq_q;

  // ***************************************************************
  // AXI4-Lite read path
  // ***************************************************************

  // One read at a time; the address is taken only while no data is pending.
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
      rdata_q <= 32'h00000000;
      rresp_q <= bmxc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      arready_q <= 1'b0;
      rresp_q <= bmxc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        bmxc_pkg::ADDR_MATRIX_CONFIGURATION: rdata_q <= cfg_q & bmxc_pkg::CFG_WRITE_MASK;
        bmxc_pkg::ADDR_ERROR_STATUS: rdata_q <= {{(32-N){1'b0}}, status_q};
        bmxc_pkg::ADDR_ERROR_ENABLE: rdata_q <= {{(32-N){1'b0}}, enable_q};
        bmxc_pkg::ADDR_ERROR_CLEAR: rdata_q <= 32'h00000000;
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= bmxc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

// *** verif/bmxc_props.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Checker of the matrix configuration block.
// ****
module bmxc_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Initiator side.
  input wire bmxc_pkg::bmxc_req_t init_req,
  input wire logic cpu_debug_mode,
  input wire bmxc_pkg::bmxc_rsp_t init_rsp
);
  logic [3:0] ar_q;
  logic [4:0] done;
  // Keeps the offset of the read in flight, since the answer comes a cycle later.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  // Ends of accesses from any initiator.
  assign done = init_rsp.ack | init_rsp.err;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_CFG_ZERO:
    assert property (s_axi_rvalid && ar_q == 4'h0 |-> (s_axi_rdata & 32'hFFE0FFB8) == 32'h0)
    else $error("Unimplemented config bit read as one");
  AST_ERR_CAUSE:
    assert property (init_rsp.err != 0 |-> (init_rsp.err & ~$past(init_req.valid & init_req.unmapped)) == 0)
    else $error("Bus error without an unmapped request");
  AST_ERR_NO_TARGET:
    assert property (init_rsp.err != 0 |-> init_rsp.target_strobe == 0 ##1 init_rsp.target_strobe == 0)
    else $error("Errored access reached a target");
  AST_DEBUG_MASK:
    assert property (init_rsp.err[1:0] != 0 |-> !$past(cpu_debug_mode))
    else $error("CPU bus error raised in debug mode");
  AST_ACK_AFTER_TARGET:
    assert property (init_rsp.target_strobe != 0 |=> init_rsp.ack == $past(init_rsp.target_strobe))
    else $error("Ack does not follow target strobe");
  AST_DONE_PULSE:
    assert property (done != 0 |=> done == 0)
    else $error("Answer pulse longer than one cycle");
  AST_ONE_ACCESS:
    assert property ($onehot0(init_rsp.target_strobe | done))
    else $error("Two accesses served at once");
  AST_WRITE_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("Write response late or early");
  AST_READ_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  AST_READ_UNMAPPED:
    assert property (s_axi_rvalid && ar_q[1:0] != 0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("Unmapped read not refused");
endmodule
bind bmxc_top bmxc_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .init_req(init_req), .cpu_debug_mode(cpu_debug_mode), .init_rsp(init_rsp));
`default_nettype wire

// *** verif/bmxc_init_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Behavioural initiators facing the matrix.
// ****
module bmxc_init_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Requests ordered by the bench, one bit per initiator.
  input wire logic [4:0] start,
  input wire logic [4:0] unm,
  input wire logic [4:0] dram,
  // Matrix side.
  input wire bmxc_pkg::bmxc_rsp_t rsp,
  output bmxc_pkg::bmxc_req_t req
);
  // A request stands until its answer pulse; then the qualifiers flip, so a late reader cannot pass by luck.
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 5; i++) begin
      if (!aresetn) begin
        req.valid[i] <= 1'b0;
        req.unmapped[i] <= 1'b0;
        req.data_ram[i] <= 1'b0;
      end else if (rsp.ack[i] || rsp.err[i]) begin
        req.valid[i] <= 1'b0;
        req.unmapped[i] <= ~req.unmapped[i];
        req.data_ram[i] <= ~req.data_ram[i];
      end else if (start[i] && !req.valid[i]) begin
        req.valid[i] <= 1'b1;
        req.unmapped[i] <= unm[i];
        req.data_ram[i] <= dram[i];
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Self-checking bench of the matrix configuration block.
// ****
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, dbg = 1'b0;
  logic [4:0] start = 5'h0, unm = 5'h0, dram = 5'h0, pv = 5'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, r;
  bmxc_pkg::bmxc_req_t req;
  bmxc_pkg::bmxc_rsp_t rsp;
  logic [3:0] q[$];
  int cyc = 0, vcyc = 0, lat = 0, n_mismatch = 0, samples_checked = 0;
  bmxc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .init_req(req), .cpu_debug_mode(dbg), .init_rsp(rsp), .irq(irq));
  bmxc_init_model u_init (.aclk(aclk), .aresetn(aresetn), .start(start), .unm(unm), .dram(dram), .rsp(rsp),
    .req(req));
  // Clock of 100 ns.
  always #50 aclk = ~aclk;
  // Logs each answer with its error flag, times the target strobe, and cuts a hung run short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    pv <= req.valid;
    for (int i = 0; i < 5; i++) begin
      if (req.valid[i] && !pv[i]) vcyc = cyc;
      if (rsp.target_strobe[i]) lat = cyc - vcyc;
      if (rsp.ack[i] || rsp.err[i]) q.push_back({rsp.err[i], 3'(i)});
    end
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; each is released once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = {30'h0, bresp};
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    r = {30'h0, rresp};
    rready <= 1'b0;
    chk(rdata, e);
    @(posedge aclk);
  endtask
  // One access from initiator i; waits for its answer and for the request to drop.
  task automatic acc(input int i, input logic u, input logic m);
    lat = 0;
    unm <= {5{u}};
    dram <= {5{m}};
    start <= 5'(1) << i;
    @(posedge aclk);
    start <= 5'h0;
    while (q.size() == 0) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  task automatic t_regs();
    rdc(4'h0, 32'h001F0041);
    // Every unimplemented bit is written as one, but the mode field only gets the defined code 010.
    wr(4'h0, 32'hFFFFFFFA);
    rdc(4'h0, 32'h001F0042);
    // Only the defined codes are written; the rest are reserved.
    for (int m = 0; m < 3; m++) begin
      wr(4'h0, 32'(m));
      rdc(4'h0, 32'(m));
    end
    wr(4'h4, 32'h1F);
    chk(r, 32'h2);
    rdc(4'h6, 32'h0);
    chk(r, 32'h2);
  endtask
  // Each initiator with its error enable off and on, then masking of the interrupt.
  task automatic t_err();
    wr(4'hC, 32'h1F);
    for (int i = 0; i < 5; i++) begin
      for (int e = 0; e < 2; e++) begin
        wr(4'h0, 32'h1 | (32'(e) << (16 + i)));
        acc(i, 1'b1, 1'b0);
        chk(32'(q.pop_front()), 32'(e * 8 + i));
        rdc(4'h4, 32'(e) << i);
        chk(32'(irq), 32'(e));
        wr(4'h8, 32'h1F);
        rdc(4'h4, 32'h0);
        chk(32'(irq), 32'h0);
      end
    end
    wr(4'hC, 32'h0);
    acc(4, 1'b1, 1'b0);
    void'(q.pop_front());
    rdc(4'h4, 32'h10);
    chk(32'(irq), 32'h0);
    wr(4'hC, 32'h1F);
    rdc(4'h4, 32'h10);
    chk(32'(irq), 32'h1);
    wr(4'h8, 32'h1F);
  endtask
  task automatic t_debug();
    dbg <= 1'b1;
    wr(4'h0, 32'h001F0001);
    for (int i = 0; i < 3; i++) begin
      acc(i, 1'b1, 1'b0);
      chk(32'(q.pop_front()), (i == 2) ? 32'hA : 32'(i));
    end
    dbg <= 1'b0;
    wr(4'h8, 32'h1F);
  endtask
  task automatic t_wait();
    for (int w = 0; w < 2; w++) begin
      wr(4'h0, 32'h001F0001 | (32'(w) << 6));
      for (int i = 0; i < 3; i++) begin
        acc(i, 1'b0, 1'b1);
        void'(q.pop_front());
        chk(32'(lat), (w == 1 && i < 2) ? 32'h2 : 32'h1);
      end
    end
  endtask
  // All five ask at once; the order of service shows the scheme.
  task automatic t_arb();
    int x;
    for (int m = 0; m < 3; m++) begin
      wr(4'h0, 32'h001F0000 | 32'(m));
      unm <= 5'h0;
      dram <= 5'h0;
      start <= 5'h1F;
      @(posedge aclk);
      start <= 5'h0;
      while (q.size() < 5) @(posedge aclk);
      for (int k = 0; k < 5; k++) begin
        // Round robin starts just above index 0, the last winner of the mode 1 pass.
        x = (m == 0) ? k : (m == 1) ? 4 - k : (k + 1) % 5;
        chk(32'(q[k]), 32'(x));
      end
      q.delete();
      repeat (2) @(posedge aclk);
    end
  endtask
  // A reset in mid-run must bring back the defaults after software changed them.
  task automatic t_reset();
    wr(4'h0, 32'h00000042);
    wr(4'hC, 32'h1F);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(4'h0, 32'h001F0041);
    rdc(4'hC, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_err();
    t_debug();
    t_wait();
    t_arb();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
